/* logic/nand_host_pkg.sv */
package nand_host_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RB_VALID_RAMP_US = 50;
  localparam int RB_VALID_VMIN_US = 10;
  localparam int VCC_WAIT_US = 100;
  localparam int RST_BUSY_MS = 1;
  localparam int T_WB_NS = 100;
  localparam int T_STROBE_LOW_NS = 30;
  localparam int T_STROBE_HIGH_NS = 20;
  localparam int NS_PER_US = 1000;
  localparam int US_PER_MS = 1000;

  // Reset release is taken as the moment the supply reaches its minimum, so the
  // ramp figure is the larger of the two and wins
  localparam int RB_VALID_US = (RB_VALID_RAMP_US > RB_VALID_VMIN_US) ?
                               RB_VALID_RAMP_US : RB_VALID_VMIN_US;
  localparam int RB_VALID_CYC = (RB_VALID_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VCC_WAIT_CYC = (VCC_WAIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_BUSY_CYC = (RST_BUSY_MS * US_PER_MS * NS_PER_US + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int T_WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYC = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (T_STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_BYTES = 5;
  localparam int LEN_W = 12;
  localparam logic [LEN_W-1:0] SET_FEAT_BYTES = 12'h004;

  // Opcodes
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] OP_READ_ID = 8'h90;
  localparam logic [7:0] OP_PARAM_PAGE = 8'hec;
  localparam logic [7:0] OP_UNIQUE_ID = 8'hed;
  localparam logic [7:0] OP_GET_FEAT = 8'hee;
  localparam logic [7:0] OP_SET_FEAT = 8'hef;
  localparam logic [7:0] OP_STATUS = 8'h70;
  localparam logic [7:0] OP_STATUS_DIE = 8'h78;
  localparam logic [7:0] OP_COL_READ = 8'h05;
  localparam logic [7:0] OP_COL_READ_CONF = 8'he0;
  localparam logic [7:0] OP_COL_WRITE = 8'h85;
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_READ_CONF = 8'h30;
  localparam logic [7:0] OP_CACHE_SEQ = 8'h31;
  localparam logic [7:0] OP_CACHE_LAST = 8'h3f;
  localparam logic [7:0] OP_COPY_CONF = 8'h35;
  localparam logic [7:0] OP_PROG = 8'h80;
  localparam logic [7:0] OP_PROG_CONF = 8'h10;
  localparam logic [7:0] OP_PROG_CACHE_CONF = 8'h15;
  localparam logic [7:0] OP_ERASE = 8'h60;
  localparam logic [7:0] OP_ERASE_CONF = 8'hd0;
  localparam logic [7:0] OP_NONE = 8'h00;

  typedef enum logic [4:0] {
    K_RESET = 5'h00, K_READ_ID = 5'h01, K_PARAM_PAGE = 5'h02, K_UNIQUE_ID = 5'h03,
    K_GET_FEAT = 5'h04, K_SET_FEAT = 5'h05, K_STATUS = 5'h06, K_STATUS_DIE = 5'h07,
    K_COL_READ = 5'h08, K_COL_WRITE = 5'h09, K_READ_MODE = 5'h0a, K_READ_PAGE = 5'h0b,
    K_CACHE_SEQ = 5'h0c, K_CACHE_RAND = 5'h0d, K_CACHE_LAST = 5'h0e, K_PROG = 5'h0f,
    K_PROG_CACHE = 5'h10, K_ERASE = 5'h11, K_COPY_READ = 5'h12, K_COPY_PROG = 5'h13
  } kind_t;

  typedef struct packed {
    logic valid;
    logic [7:0] op1;
    logic [2:0] naddr;
    logic din;
    logic conf_en;
    logic [7:0] conf;
    logic busy_after;
    logic ok_busy;
  } cmd_spec_t;

  typedef enum logic [1:0] {
    CYC_CMD = 2'h0, CYC_ADDR = 2'h1, CYC_DIN = 2'h2, CYC_DOUT = 2'h3
  } cyc_kind_t;

  typedef struct packed {
    cyc_kind_t kind;
    logic [7:0] data;
  } cyc_req_t;

  function automatic cmd_spec_t mk(input logic [7:0] op, input logic [2:0] na,
                                   input logic din, input logic ce, input logic [7:0] cf,
                                   input logic busy, input logic okb);
    mk = '{1'b1, op, na, din, ce, cf, busy, okb};
  endfunction

  function automatic cmd_spec_t cmd_spec(input logic [4:0] k);
    case (k)
      K_RESET: cmd_spec = mk(OP_RESET, 3'h0, 1'b0, 1'b0, OP_NONE, 1'b1, 1'b1);
      K_READ_ID: cmd_spec = mk(OP_READ_ID, 3'h1, 1'b0, 1'b0, OP_NONE, 1'b0, 1'b0);
      K_PARAM_PAGE: cmd_spec = mk(OP_PARAM_PAGE, 3'h1, 1'b0, 1'b0, OP_NONE, 1'b1, 1'b0);
      K_UNIQUE_ID: cmd_spec = mk(OP_UNIQUE_ID, 3'h1, 1'b0, 1'b0, OP_NONE, 1'b1, 1'b0);
      K_GET_FEAT: cmd_spec = mk(OP_GET_FEAT, 3'h1, 1'b0, 1'b0, OP_NONE, 1'b1, 1'b0);
      K_SET_FEAT: cmd_spec = mk(OP_SET_FEAT, 3'h1, 1'b1, 1'b0, OP_NONE, 1'b1, 1'b0);
      K_STATUS: cmd_spec = mk(OP_STATUS, 3'h0, 1'b0, 1'b0, OP_NONE, 1'b0, 1'b1);
      K_STATUS_DIE: cmd_spec = mk(OP_STATUS_DIE, 3'h3, 1'b0, 1'b0, OP_NONE, 1'b0, 1'b1);
      K_COL_READ: cmd_spec = mk(OP_COL_READ, 3'h2, 1'b0, 1'b1, OP_COL_READ_CONF, 1'b0, 1'b0);
      K_COL_WRITE: cmd_spec = mk(OP_COL_WRITE, 3'h2, 1'b1, 1'b0, OP_NONE, 1'b0, 1'b0);
      K_READ_MODE: cmd_spec = mk(OP_READ, 3'h0, 1'b0, 1'b0, OP_NONE, 1'b0, 1'b0);
      K_READ_PAGE: cmd_spec = mk(OP_READ, 3'h5, 1'b0, 1'b1, OP_READ_CONF, 1'b1, 1'b0);
      K_CACHE_SEQ: cmd_spec = mk(OP_CACHE_SEQ, 3'h0, 1'b0, 1'b0, OP_NONE, 1'b1, 1'b0);
      K_CACHE_RAND: cmd_spec = mk(OP_READ, 3'h5, 1'b0, 1'b1, OP_CACHE_SEQ, 1'b1, 1'b0);
      K_CACHE_LAST: cmd_spec = mk(OP_CACHE_LAST, 3'h0, 1'b0, 1'b0, OP_NONE, 1'b1, 1'b0);
      K_PROG: cmd_spec = mk(OP_PROG, 3'h5, 1'b1, 1'b1, OP_PROG_CONF, 1'b1, 1'b0);
      K_PROG_CACHE: cmd_spec = mk(OP_PROG, 3'h5, 1'b1, 1'b1, OP_PROG_CACHE_CONF, 1'b1, 1'b0);
      K_ERASE: cmd_spec = mk(OP_ERASE, 3'h3, 1'b0, 1'b1, OP_ERASE_CONF, 1'b1, 1'b0);
      K_COPY_READ: cmd_spec = mk(OP_READ, 3'h5, 1'b0, 1'b1, OP_COPY_CONF, 1'b1, 1'b0);
      K_COPY_PROG: cmd_spec = mk(OP_COL_WRITE, 3'h5, 1'b1, 1'b1, OP_PROG_CONF, 1'b1, 1'b0);
      default: cmd_spec = '0;
    endcase
  endfunction

endpackage

/* logic/nand_cycle_gen.sv */
`timescale 1ns/100ps
module nand_cycle_gen #(
  parameter int LOW_CYC = nand_host_pkg::STROBE_LOW_CYC,
  parameter int HIGH_CYC = nand_host_pkg::STROBE_HIGH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sel_i,
  input wire logic start_i,
  input wire nand_host_pkg::cyc_req_t req_i,
  input wire logic [7:0] io_sync_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic read_strobe_n_o,
  output logic [7:0] io_o,
  output logic io_oe_o
);
  localparam logic [7:0] LOW_LAST = 8'(LOW_CYC - 1);
  localparam logic [7:0] HIGH_LAST = 8'(HIGH_CYC - 1);

  logic act_r;
  logic low_r;
  logic [7:0] cnt_r;
  logic is_dout_r;

  wire logic go = start_i && !act_r;
  wire logic low_end = act_r && low_r && (cnt_r == LOW_LAST);
  wire logic high_end = act_r && !low_r && (cnt_r == HIGH_LAST);
  wire logic is_dout = (req_i.kind == nand_host_pkg::CYC_DOUT);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      act_r <= 1'b0;
      low_r <= 1'b0;
      cnt_r <= 8'h00;
      is_dout_r <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      ce_n_o <= 1'b1;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      io_o <= 8'h00;
      io_oe_o <= 1'b0;
    end else begin
      ce_n_o <= !sel_i;
      done_o <= high_end;
      if (go) begin
        // Only asynchronous strobe cycles are ever produced
        act_r <= 1'b1;
        low_r <= 1'b1;
        cnt_r <= 8'h00;
        is_dout_r <= is_dout;
        cle_o <= (req_i.kind == nand_host_pkg::CYC_CMD);
        ale_o <= (req_i.kind == nand_host_pkg::CYC_ADDR);
        we_n_o <= is_dout;
        read_strobe_n_o <= !is_dout;
        io_o <= req_i.data;
        io_oe_o <= !is_dout;
      end else if (low_end) begin
        // The bus is read through a two-stage synchroniser, so the strobe low time
        // must exceed the access time by at least two cycles
        if (is_dout_r) begin
          rdata_o <= io_sync_i;
        end
        low_r <= 1'b0;
        cnt_r <= 8'h00;
        we_n_o <= 1'b1;
        read_strobe_n_o <= 1'b1;
      end else if (high_end) begin
        act_r <= 1'b0;
        cle_o <= 1'b0;
        ale_o <= 1'b0;
        io_oe_o <= 1'b0;
      end else if (act_r) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // nand_cycle_gen

/* logic/nand_host_ctrl.sv */
`timescale 1ns/100ps
module nand_host_ctrl #(
  parameter bit RB_MONITOR = 1'b1,
  parameter int RB_VALID_CYC = nand_host_pkg::RB_VALID_CYC,
  parameter int VCC_WAIT_CYC = nand_host_pkg::VCC_WAIT_CYC,
  parameter int RST_BUSY_CYC = nand_host_pkg::RST_BUSY_CYC,
  parameter int T_WB_CYC = nand_host_pkg::T_WB_CYC,
  parameter int LEN_W = nand_host_pkg::LEN_W
) (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic CMD_VALID_I,
  input wire logic [4:0] CMD_KIND_I,
  input wire logic [39:0] CMD_ADDR_I,
  input wire logic [LEN_W-1:0] CMD_LEN_I,
  output logic CMD_READY_O,
  output logic CMD_DONE_O,
  output logic CMD_ERR_O,
  input wire logic [7:0] WR_DATA_I,
  input wire logic WR_VALID_I,
  output logic WR_READY_O,
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic INIT_DONE_O,
  output logic CE_N_O,
  output logic CLE_O,
  output logic ALE_O,
  output logic WE_N_O,
  output logic READ_STROBE_N_O,
  output logic WP_N_O,
  input wire logic [7:0] IO_I,
  output logic [7:0] IO_O,
  output logic IO_OE_O,
  input wire logic RB_N_I
);
  localparam int TMR_W = 20;
  localparam logic [TMR_W-1:0] TMR_MAX = '1;
  localparam logic [TMR_W-1:0] RBV_LIM = TMR_W'(RB_VALID_CYC);
  localparam logic [TMR_W-1:0] VCC_LIM = TMR_W'(VCC_WAIT_CYC);
  localparam logic [TMR_W-1:0] RST_LIM = TMR_W'(RST_BUSY_CYC);
  localparam logic [TMR_W-1:0] TWB_LIM = TMR_W'(T_WB_CYC);
  localparam logic [LEN_W-1:0] LEN_ZERO = '0;
  localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

  typedef enum logic [3:0] {
    ST_PWR = 4'h0, ST_RST_CMD = 4'h1, ST_RST_BUSY = 4'h3, ST_IDLE = 4'h2,
    ST_OP1 = 4'h6, ST_ADDR = 4'h7, ST_DIN = 4'h5, ST_CONF = 4'h4,
    ST_WAIT_RB = 4'hc, ST_DOUT = 4'hd, ST_DONE = 4'hf
  } state_t;

  state_t state_r, state_nxt;
  logic pend_r, pend_nxt;
  logic [TMR_W-1:0] tmr_r;
  nand_host_pkg::cmd_spec_t spec_r, spec_nxt;
  logic [39:0] addr_r;
  logic [2:0] idx_r, idx_nxt;
  logic [LEN_W-1:0] cnt_r, cnt_nxt;
  logic err_r, err_nxt;
  logic init_r, init_nxt;
  logic [7:0] io_s1_r, io_s2_r;
  logic rb_s1_r, rb_s2_r;
  logic cyc_done;
  logic [7:0] cyc_rdata;

  wire logic rb_ready = rb_s2_r;
  wire logic cmd_take = CMD_VALID_I && CMD_READY_O;
  wire logic wr_take = (state_r == ST_DIN) && !pend_r && WR_READY_O && WR_VALID_I;
  wire nand_host_pkg::cmd_spec_t take_spec = nand_host_pkg::cmd_spec(CMD_KIND_I);
  wire logic [LEN_W-1:0] take_len = (CMD_KIND_I == nand_host_pkg::K_SET_FEAT) ?
                                    nand_host_pkg::SET_FEAT_BYTES : CMD_LEN_I;
  // A busy target takes only the commands marked valid during busy; hold the rest
  wire logic op_gate = spec_r.ok_busy || rb_ready;
  wire logic [7:0] addr_byte = addr_r[{idx_r, 3'b000} +: 8];
  wire logic addr_more = (idx_r != spec_r.naddr);
  wire logic cnt_more = (cnt_r != LEN_ZERO);

  wire state_t after_busy = spec_r.din ? ST_DONE : ST_DOUT;
  wire state_t after_conf = spec_r.busy_after ? ST_WAIT_RB : after_busy;
  wire state_t after_din = spec_r.conf_en ? ST_CONF : after_conf;
  wire state_t after_addr = spec_r.din ? ST_DIN : after_din;
  wire state_t after_op = (spec_r.naddr != 3'h0) ? ST_ADDR : after_addr;

  wire logic pwr_ok = RB_MONITOR ? ((tmr_r >= RBV_LIM) && rb_ready)
                                 : (tmr_r >= VCC_LIM);
  // Busy may not fall until tWB after the confirm, so ready is not trusted before it
  wire logic rst_ok = RB_MONITOR ? ((tmr_r >= TWB_LIM) && rb_ready)
                                 : (tmr_r >= RST_LIM);
  wire logic op_ok = (tmr_r >= TWB_LIM) && rb_ready;

  wire logic can_issue = (state_r == ST_RST_CMD) ||
                         ((state_r == ST_OP1) && op_gate) ||
                         ((state_r == ST_ADDR) && addr_more) ||
                         wr_take ||
                         (state_r == ST_CONF) ||
                         ((state_r == ST_DOUT) && cnt_more);
  wire logic cyc_start = can_issue && !pend_r;
  wire logic sel = (state_r != ST_PWR) && (state_r != ST_IDLE) && (state_r != ST_DONE);

  nand_host_pkg::cyc_req_t cyc_req;
  always_comb begin
    case (state_r)
      ST_RST_CMD: cyc_req = '{nand_host_pkg::CYC_CMD, nand_host_pkg::OP_RESET};
      ST_OP1: cyc_req = '{nand_host_pkg::CYC_CMD, spec_r.op1};
      ST_ADDR: cyc_req = '{nand_host_pkg::CYC_ADDR, addr_byte};
      ST_DIN: cyc_req = '{nand_host_pkg::CYC_DIN, WR_DATA_I};
      ST_CONF: cyc_req = '{nand_host_pkg::CYC_CMD, spec_r.conf};
      default: cyc_req = '{nand_host_pkg::CYC_DOUT, 8'h00};
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    spec_nxt = spec_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    err_nxt = err_r;
    init_nxt = init_r;
    if (cyc_start) begin
      pend_nxt = 1'b1;
    end else if (cyc_done) begin
      pend_nxt = 1'b0;
    end
    case (state_r)
      ST_PWR: if (pwr_ok) state_nxt = ST_RST_CMD;
      ST_RST_CMD: if (cyc_done) state_nxt = ST_RST_BUSY;
      ST_RST_BUSY: begin
        if (rst_ok) begin
          state_nxt = ST_IDLE;
          init_nxt = 1'b1;
        end
      end
      ST_IDLE: begin
        if (cmd_take) begin
          spec_nxt = take_spec;
          idx_nxt = 3'h0;
          cnt_nxt = take_len;
          err_nxt = !take_spec.valid;
          state_nxt = take_spec.valid ? ST_OP1 : ST_DONE;
        end
      end
      ST_OP1: if (cyc_done) state_nxt = after_op;
      ST_ADDR: begin
        if (cyc_start) idx_nxt = idx_r + 3'h1;
        if (!pend_r && !addr_more) state_nxt = after_addr;
      end
      ST_DIN: begin
        if (cyc_start) cnt_nxt = cnt_r - LEN_ONE;
        if (!pend_r && !cnt_more) state_nxt = after_din;
      end
      ST_CONF: if (cyc_done) state_nxt = after_conf;
      ST_WAIT_RB: if (op_ok) state_nxt = after_busy;
      ST_DOUT: begin
        if (cyc_start) cnt_nxt = cnt_r - LEN_ONE;
        if (!pend_r && !cnt_more) state_nxt = ST_DONE;
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_PWR;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      io_s1_r <= IO_I;
      io_s2_r <= io_s1_r;
      rb_s1_r <= RB_N_I;
      rb_s2_r <= rb_s1_r;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      state_r <= ST_PWR;
      pend_r <= 1'b0;
      tmr_r <= '0;
      spec_r <= '0;
      addr_r <= 40'h00_0000_0000;
      idx_r <= 3'h0;
      cnt_r <= LEN_ZERO;
      err_r <= 1'b0;
      init_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      tmr_r <= (state_nxt != state_r) ? '0 : ((tmr_r == TMR_MAX) ? tmr_r : tmr_r + 1'b1);
      spec_r <= spec_nxt;
      if (cmd_take) addr_r <= CMD_ADDR_I;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      err_r <= err_nxt;
      init_r <= init_nxt;
    end
  end

  // Write protect stays low until the first reset has finished, so a supply
  // glitch during start-up cannot program or erase
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      CMD_READY_O <= 1'b0;
      CMD_DONE_O <= 1'b0;
      CMD_ERR_O <= 1'b0;
      WR_READY_O <= 1'b0;
      RD_DATA_O <= 8'h00;
      RD_VALID_O <= 1'b0;
      INIT_DONE_O <= 1'b0;
      WP_N_O <= 1'b0;
    end else begin
      CMD_READY_O <= (state_nxt == ST_IDLE);
      CMD_DONE_O <= (state_r == ST_DONE);
      CMD_ERR_O <= (state_r == ST_DONE) && err_r;
      WR_READY_O <= (state_nxt == ST_DIN) && !pend_nxt && (cnt_nxt != LEN_ZERO);
      RD_VALID_O <= cyc_done && (state_r == ST_DOUT);
      if (cyc_done && (state_r == ST_DOUT)) RD_DATA_O <= cyc_rdata;
      INIT_DONE_O <= init_nxt;
      WP_N_O <= init_nxt;
    end
  end

  nand_cycle_gen u_cycle (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RSTN_I),
    .sel_i(sel),
    .start_i(cyc_start),
    .req_i(cyc_req),
    .io_sync_i(io_s2_r),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .ce_n_o(CE_N_O),
    .cle_o(CLE_O),
    .ale_o(ALE_O),
    .we_n_o(WE_N_O),
    .read_strobe_n_o(READ_STROBE_N_O),
    .io_o(IO_O),
    .io_oe_o(IO_OE_O)
  );
endmodule // nand_host_ctrl

/* bench/nand_host_ctrl_chk.sv */
`timescale 1ns/100ps
module nand_host_ctrl_chk #(
  parameter int RB_VALID_CYC = 50
) (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic CMD_VALID_I,
  input wire logic [4:0] CMD_KIND_I,
  input wire logic CMD_READY_O,
  input wire logic CMD_DONE_O,
  input wire logic CMD_ERR_O,
  input wire logic INIT_DONE_O,
  input wire logic CE_N_O,
  input wire logic CLE_O,
  input wire logic ALE_O,
  input wire logic WE_N_O,
  input wire logic READ_STROBE_N_O,
  input wire logic [7:0] IO_O,
  input wire logic IO_OE_O,
  input wire logic RB_N_I
);
  logic [15:0] up_cnt_r;
  logic [15:0] up_cnt_nxt;
  // Saturates so a long run never wraps back under the power-up figure
  assign up_cnt_nxt = (up_cnt_r == 16'hffff) ? up_cnt_r : up_cnt_r + 16'h0001;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) up_cnt_r <= 16'h0000;
    else up_cnt_r <= up_cnt_nxt;
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  property p_pwr_wait;
    $fell(CE_N_O) && !INIT_DONE_O |-> 32'(up_cnt_r) >= RB_VALID_CYC;
  endproperty
  a_pwr_wait: assert property (p_pwr_wait) else $error("target selected too early");
  property p_first_reset;
    $rose(WE_N_O) && CLE_O && !INIT_DONE_O |-> IO_O == 8'hff;
  endproperty
  a_first_reset: assert property (p_first_reset) else $error("first opcode not reset");
  property p_ready_init;
    CMD_READY_O |-> INIT_DONE_O;
  endproperty
  a_ready_init: assert property (p_ready_init) else $error("ready before init");
  property p_init_hold;
    $rose(INIT_DONE_O) |-> $past(RB_N_I, 1) && $past(RB_N_I, 2);
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init ended while busy");
  property p_cmd_latch;
    $rose(WE_N_O) && !CE_N_O |-> READ_STROBE_N_O && !(CLE_O && ALE_O) && IO_OE_O;
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("bad latch levels");
  property p_busy_gate;
    $fell(WE_N_O) && CLE_O && !(IO_O inside {8'hff, 8'h70, 8'h78}) |-> RB_N_I && $past(RB_N_I, 2);
  endproperty
  a_busy_gate: assert property (p_busy_gate) else $error("opcode sent while busy");
  property p_status_noaddr;
    $rose(WE_N_O) && CLE_O && IO_O == 8'h70 |=> !ALE_O [*8];
  endproperty
  a_status_noaddr: assert property (p_status_noaddr) else $error("address after status");
  property p_unsup;
    CMD_VALID_I && CMD_READY_O && CMD_KIND_I > 5'h13 |-> ##2 (CMD_DONE_O && CMD_ERR_O && CE_N_O);
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported kind not refused");
endmodule // nand_host_ctrl_chk
bind nand_host_ctrl nand_host_ctrl_chk #(.RB_VALID_CYC(RB_VALID_CYC)) u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .CMD_VALID_I(CMD_VALID_I), .CMD_KIND_I(CMD_KIND_I),
  .CMD_READY_O(CMD_READY_O), .CMD_DONE_O(CMD_DONE_O), .CMD_ERR_O(CMD_ERR_O),
  .INIT_DONE_O(INIT_DONE_O), .CE_N_O(CE_N_O), .CLE_O(CLE_O), .ALE_O(ALE_O), .WE_N_O(WE_N_O),
  .READ_STROBE_N_O(READ_STROBE_N_O), .IO_O(IO_O), .IO_OE_O(IO_OE_O), .RB_N_I(RB_N_I));

/* bench/nand_dev_model.sv */
`timescale 1ns/100ps
module nand_dev_model (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [7:0] io_i,
  input wire logic busy_req_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic rb_n_o
);
  logic [9:0] logq[$];
  logic cmd_busy = 1'b0;
  logic pwr_ok = 1'b0;
  logic slow = 1'b0;
  logic [7:0] dcnt = 8'h00;
  logic [7:0] dout = 8'h00;
  int busy_n = 0;
  // Held low until the supply settles, so a host trusting it early stalls
  initial #400 pwr_ok = 1'b1;
  // Pull-up wins unless some die sinks the line
  assign rb_n_o = pwr_ok && busy_n == 0 && !busy_req_i;
  assign io_oe_o = !ce_n_i && !read_strobe_n_i;
  // Released bus shows the inverse so stale data never passes for fresh
  assign io_o = io_oe_o ? dout : ~dout;
  always @(negedge read_strobe_n_i) begin
    if (!ce_n_i) begin
      dout = dcnt * 8'h07 + 8'h03;
      dcnt = dcnt + 8'h01;
    end
  end
  // Only the asynchronous interface exists, from power-up on
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      logq.push_back({cle_i, ale_i, io_i});
      if (cle_i) cmd_busy = !rb_n_o;
      // Busy die acts only on reset; status never starts a busy time
      if (cle_i && (rb_n_o || io_i == 8'hff) &&
          io_i inside {8'hff, 8'h30, 8'h31, 8'h3f, 8'h35, 8'h10, 8'h15, 8'hd0}) begin
        slow = !slow;
        fork
          begin
            busy_n++;
            #(slow ? 2000 : 60);
            busy_n--;
          end
        join_none
      end
    end
  end
endmodule // nand_dev_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, cv = 1'b0, wv = 1'b1, brq = 1'b0, wpend = 1'b0, e;
  logic [4:0] kind = 5'h00;
  logic [39:0] addr = 40'h0;
  logic [11:0] len = 12'h000;
  logic [7:0] wd = 8'h00, dio, io_o, rdd;
  logic rdy, done, err, wrdy, rdv, idone, ce_n, cle, ale, we_n, rs_n, wp_n, oe, rb_n;
  int errors = 0, samples_checked = 0, seed = 88, rc = 0, i, k;
  logic [9:0] exq[$];
  logic [7:0] rdq[$], wq[$];
  // Per-kind tables, kind 0 in the lowest field
  logic [159:0] op = 160'h850060808_03f00310000850578_70efeeedec90ff;
  logic [159:0] cf = 160'h1035d015100031003000_00e00000000000000000;
  logic [79:0] na = 80'h55355050502230111110;
  logic [19:0] din = 20'h98220, cfm = 20'hfa900;
  wire [7:0] bus = oe ? io_o : dio;
  logic idone2, ce2, cle2, ale2, we2, rs2, oe2, rb2;
  logic [7:0] dio2, io2;
  wire [7:0] bus2 = oe2 ? io2 : dio2;
  nand_host_ctrl #(.RB_VALID_CYC(50), .VCC_WAIT_CYC(60), .RST_BUSY_CYC(200), .T_WB_CYC(4)) dut (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .CMD_VALID_I(cv), .CMD_KIND_I(kind), .CMD_ADDR_I(addr),
    .CMD_LEN_I(len), .CMD_READY_O(rdy), .CMD_DONE_O(done), .CMD_ERR_O(err), .WR_DATA_I(wd),
    .WR_VALID_I(wv), .WR_READY_O(wrdy), .RD_DATA_O(rdd), .RD_VALID_O(rdv), .INIT_DONE_O(idone),
    .CE_N_O(ce_n), .CLE_O(cle), .ALE_O(ale), .WE_N_O(we_n), .READ_STROBE_N_O(rs_n),
    .WP_N_O(wp_n), .IO_I(bus), .IO_O(io_o), .IO_OE_O(oe), .RB_N_I(rb_n));
  nand_dev_model dev (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .read_strobe_n_i(rs_n), .io_i(bus), .busy_req_i(brq), .io_o(dio), .io_oe_o(), .rb_n_o(rb_n));
  // Second controller trusts time alone at power-up; its reset wait outlasts the slow busy
  nand_host_ctrl #(.RB_MONITOR(1'b0), .RB_VALID_CYC(50), .VCC_WAIT_CYC(60),
    .RST_BUSY_CYC(500), .T_WB_CYC(4)) dut_nomon (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .CMD_VALID_I(1'b0), .CMD_KIND_I(5'h00),
    .CMD_ADDR_I(40'h0), .CMD_LEN_I(12'h000), .CMD_READY_O(), .CMD_DONE_O(), .CMD_ERR_O(),
    .WR_DATA_I(8'h00), .WR_VALID_I(1'b0), .WR_READY_O(), .RD_DATA_O(), .RD_VALID_O(),
    .INIT_DONE_O(idone2), .CE_N_O(ce2), .CLE_O(cle2), .ALE_O(ale2), .WE_N_O(we2),
    .READ_STROBE_N_O(rs2), .WP_N_O(), .IO_I(bus2), .IO_O(io2), .IO_OE_O(oe2), .RB_N_I(rb2));
  nand_dev_model dev2 (.ce_n_i(ce2), .cle_i(cle2), .ale_i(ale2), .we_n_i(we2),
    .read_strobe_n_i(rs2), .io_i(bus2), .busy_req_i(1'b0), .io_o(dio2), .io_oe_o(),
    .rb_n_o(rb2));
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    chk(10'h3ff, 10'h000);
    print_verdict();
  endtask
  // Handshakes seen at the falling edge are the ones the next rising edge takes
  always @(negedge clk) begin
    if (wpend) begin
      wq.push_back(wd);
      wd = 8'($random(seed));
    end
    wpend = wv && wrdy;
    if (rdv) rdq.push_back(rdd);
  end
  task automatic run(input int k, output logic e);
    int j;
    int n;
    n = 2 + k % 3;
    kind = k[4:0];
    addr = {8'($random(seed)), 32'($random(seed))};
    len = 12'(n);
    cv = 1'b1;
    for (j = 0; j < 4000 && rdy !== 1'b1; j++) @(negedge clk);
    if (j >= 4000) hang();
    @(negedge clk);
    cv = 1'b0;
    for (j = 0; j < 30000 && done !== 1'b1; j++) @(negedge clk);
    if (j >= 30000) hang();
    e = err;
    exq.delete();
    if (k < 20) begin
      exq.push_back({2'b10, op[8*k +: 8]});
      for (j = 0; j < na[4*k +: 4]; j++) exq.push_back({2'b01, addr[8*j +: 8]});
      foreach (wq[m]) exq.push_back({2'b00, wq[m]});
      if (cfm[k]) exq.push_back({2'b10, cf[8*k +: 8]});
      chk(10'(wq.size()), din[k] ? (k == 5 ? 10'h004 : 10'(n)) : 10'h000);
      chk(10'(rdq.size()), din[k] ? 10'h000 : 10'(n));
    end
    foreach (rdq[m]) begin
      chk({2'b00, rdq[m]}, {2'b00, 8'(rc * 7 + 3)});
      rc++;
    end
    chk(10'(dev.logq.size()), 10'(exq.size()));
    foreach (exq[m]) chk(dev.logq[m], exq[m]);
    dev.logq.delete();
    wq.delete();
    rdq.delete();
  endtask
  // Holds the line busy from outside, then releases it w cycles after the command starts
  task automatic brun(input int k, input int w, input logic [9:0] x);
    logic e2;
    brq = 1'b1;
    // Let the synchronised busy settle: a command taken at once could still see ready
    repeat (4) @(negedge clk);
    fork
      run(k, e2);
      begin
        repeat (w) @(negedge clk);
        chk({dev.cmd_busy, 9'(dev.logq.size())}, x);
        brq = 1'b0;
      end
    join
  endtask
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    for (i = 0; i < 4000 && idone !== 1'b1; i++) @(negedge clk);
    if (i >= 4000) hang();
    chk({wp_n, 9'(dev.logq.size())}, 10'h201);
    chk(dev.logq[0], 10'h2ff);
    dev.logq.delete();
    for (i = i; i < 4000 && idone2 !== 1'b1; i++) @(negedge clk);
    if (i >= 4000) hang();
    chk({9'h0, i >= 60 + 500}, 10'h001);
    chk({1'b0, 9'(dev2.logq.size())}, 10'h001);
    chk(dev2.logq[0], 10'h2ff);
    for (k = 0; k < 20; k++) begin
      run(k, e);
      chk({9'h0, e}, 10'h000);
    end
    repeat (3) begin
      run(20 + ($unsigned($random(seed)) % 12), e);
      chk({9'h0, e}, 10'h001);
    end
    brun(6, 200, 10'h200);
    brun(7, 200, 10'h200);
    brun(1, 60, 10'h200);
    brun(0, 40, 10'h201);
    print_verdict();
  end
endmodule // tb_top
